// ---- rtl/compare_waveform_regs.svh ----
// register offsets, field positions and reset values of the waveform channels
`ifndef COMPARE_WAVEFORM_REGS_SVH
`define COMPARE_WAVEFORM_REGS_SVH

// ==========================================================
// offsets (byte addresses)
`define OFF_TIMER_CTRL     12'h000
`define OFF_CHAN_ENABLE    12'h004
`define OFF_FUNC_SELECT    12'h008
`define OFF_MATCH_FLAGS    12'h00c
`define OFF_TIMER_COUNT    12'h010
`define OFF_WAVE_CTRL_BASE 12'h020
`define OFF_COMPARE_BASE   12'h040
`define OFF_BANK_MASK      12'hfe0

// ==========================================================
// field positions
`define RST_SEL_LSB        0
`define RST_SEL_MSB        1
`define TIMER_RUN_BIT      4
`define WAVE_CTRL_MSB      5

// ==========================================================
// reset values and constants
`define RESET_TIMER_CTRL   5'h00
`define RESET_CHAN_BITS    8'h00
`define RESET_WAVE_CTRL    6'h00
`define RESET_COMPARE      16'h0000
`define TIMER_TOP          16'hffff
`define TIMER_ZERO         16'h0000
`define RESET_EXTRA_TICKS  16'h0001
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ---- rtl/compare_waveform_pkg.sv ----
// types shared by the waveform channel block
package compare_waveform_pkg;

   // ==========================================================
   // modes and selections
   typedef enum logic [2:0] {
      MODE_SINGLE   = 3'h0,
      MODE_INVERTED = 3'h1
   } wave_mode_e;

   typedef enum logic [1:0] {
      RESET_FREE   = 2'h0,
      RESET_ON_CH0 = 2'h1
   } timer_reset_e;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic       invertOut;
      logic       reloadTiming;
      logic       defaultLevel;
      logic [2:0] waveModeSel;
   } chan_ctrl_s;

   typedef struct packed {
      logic [15:0] count;
      logic        tick;
      logic        wrap;
   } timer_info_s;

endpackage

// ---- rtl/wave_channel.sv ----
// one compare channel: compare buffering, waveform level and pin register
`timescale 1ns/1ps
module wave_channel (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  compare_waveform_pkg::timer_info_s timer,
   input  compare_waveform_pkg::chan_ctrl_s  ctrl,
   input  wire logic                        chanEnable,
   input  wire logic                        funcSelect,
   input  wire logic                        cmpWrite,
   input  wire logic [15:0]                 cmpData,
   output logic [15:0]                      activeCmp,
   output logic                             matchEvent,
   output logic                             pinLevel
);
   import compare_waveform_pkg::*;
   `include "compare_waveform_regs.svh"

   logic [15:0] bufCmp_q;
   logic [15:0] activeCmp_q;
   logic        genLevel_q;
   logic        genLevel_d;
   logic        pinLevel_q;

   // ==========================================================
   // decode
   wire waveActive = chanEnable && !funcSelect;
   wire countMatch = timer.tick && (timer.count == activeCmp_q);
   wire atZero     = timer.tick && (timer.count == `TIMER_ZERO);
   wire isSingle   = ctrl.waveModeSel == MODE_SINGLE;
   wire isInverted = ctrl.waveModeSel == MODE_INVERTED;
   // deferred reload waits for the timer wrap, so a period never mixes values
   wire loadNow    = cmpWrite && !ctrl.reloadTiming;
   wire loadWrap   = ctrl.reloadTiming && timer.wrap;

   assign activeCmp  = activeCmp_q;
   assign matchEvent = countMatch && waveActive;
   assign pinLevel   = pinLevel_q;

   // ==========================================================
   // waveform level
   always_comb begin
      genLevel_d = genLevel_q;
      if (!waveActive) begin
         genLevel_d = ctrl.defaultLevel;
      end else if (countMatch && isSingle) begin
         genLevel_d = 1'b1;
      end else if (atZero && isSingle) begin
         genLevel_d = 1'b0;
      end else if (countMatch && isInverted) begin
         genLevel_d = !genLevel_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bufCmp_q    <= `RESET_COMPARE;
         activeCmp_q <= `RESET_COMPARE;
         genLevel_q  <= 1'b0;
         pinLevel_q  <= 1'b0;
      end else begin
         if (cmpWrite) begin
            bufCmp_q <= cmpData;
         end
         if (loadNow) begin
            activeCmp_q <= cmpData;
         end else if (loadWrap) begin
            activeCmp_q <= cmpWrite ? cmpData : bufCmp_q;
         end
         genLevel_q <= genLevel_d;
         pinLevel_q <= genLevel_d ^ ctrl.invertOut;
      end
   end

   // ==========================================================
   // checks
   chk_single_high: assert property (@(posedge clk) disable iff (!rst_n)
      waveActive && isSingle && countMatch |=> genLevel_q)
      else $error("single mode level not high after match");

   chk_single_low: assert property (@(posedge clk) disable iff (!rst_n)
      waveActive && isSingle && atZero && !countMatch |=> !genLevel_q)
      else $error("single mode level not low after zero");

   chk_inv_toggle: assert property (@(posedge clk) disable iff (!rst_n)
      waveActive && isInverted && countMatch
      |=> genLevel_q != $past(genLevel_q))
      else $error("inverted mode did not toggle on match");

   chk_disabled_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !waveActive |=> genLevel_q == $past(ctrl.defaultLevel))
      else $error("disabled channel not at default level");

   chk_pin_invert: assert property (@(posedge clk) disable iff (!rst_n)
      pinLevel_q == (genLevel_q ^ $past(ctrl.invertOut)))
      else $error("pin level does not follow inversion");

endmodule

// ---- rtl/compare_waveform_channels.sv ----
`timescale 1ns/1ps
module compare_waveform_channels (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        tickA,
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [7:0]       waveOutPin,
   output logic [7:0]       matchIrqFlag
);
   import compare_waveform_pkg::*;
   `include "compare_waveform_regs.svh"

   localparam int CHANNELS = 8;

   // ==========================================================
   // state
   logic [4:0]   timerCtrl_q;
   logic [7:0]   chanEnable_q;
   logic [7:0]   funcSelect_q;
   logic [7:0]   flags_q;
   logic [7:0]   flags_d;
   logic [15:0]  count_q;
   logic [15:0]  count_d;
   chan_ctrl_s   waveCtrl_q [CHANNELS];
   logic [15:0]  activeCmp [CHANNELS];
   logic [7:0]   matchVec;
   logic [7:0]   pinVec;
   logic [11:0]  awAddr_q;
   logic [31:0]  wData_q;
   logic [3:0]   wStrb_q;
   logic         awHeld_q;
   logic         wHeld_q;
   logic         bvalid_q;
   logic [1:0]   bresp_q;
   logic         rvalid_q;
   logic [31:0]  rdata_q;
   logic [1:0]   rresp_q;
   logic [31:0]  readMux;
   logic         readHit;
   timer_info_s  timerInfo;

   function automatic logic [31:0] mergeStrb(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0]  strb);
      logic [31:0] res;
      res = oldVal;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = newVal[8*i +: 8];
         end
      end
      return res;
   endfunction

   // ==========================================================
   // write decode
   wire doWrite     = awHeld_q && wHeld_q && !bvalid_q;
   wire wrCtrl      = awAddr_q == `OFF_TIMER_CTRL;
   wire wrEnable    = awAddr_q == `OFF_CHAN_ENABLE;
   wire wrFunc      = awAddr_q == `OFF_FUNC_SELECT;
   wire wrFlags     = awAddr_q == `OFF_MATCH_FLAGS;
   wire wrCount     = awAddr_q == `OFF_TIMER_COUNT;
   wire wrWaveBank  = (awAddr_q & `OFF_BANK_MASK) == `OFF_WAVE_CTRL_BASE;
   wire wrCmpBank   = (awAddr_q & `OFF_BANK_MASK) == `OFF_COMPARE_BASE;
   wire wrAligned   = awAddr_q[1:0] == 2'h0;
   wire wrChanOk    = wrAligned;
   wire wrMapped    = wrAligned && (wrCtrl || wrEnable || wrFunc || wrFlags
                      || wrCount || wrWaveBank || wrCmpBank);
   wire [2:0] wrIdx = awAddr_q[4:2];
   wire [31:0] ctrlMerged = mergeStrb({27'h0, timerCtrl_q}, wData_q, wStrb_q);
   wire [31:0] enMerged   = mergeStrb({24'h0, chanEnable_q}, wData_q, wStrb_q);
   wire [31:0] fsMerged   = mergeStrb({24'h0, funcSelect_q}, wData_q, wStrb_q);
   wire [7:0]  flagClear  = (doWrite && wrFlags && wStrb_q[0])
                            ? wData_q[7:0] : 8'h00;
   wire [31:0] countMerged = mergeStrb({16'h0, count_q}, wData_q, wStrb_q);

   // ==========================================================
   // base timer
   wire timerRun   = timerCtrl_q[`TIMER_RUN_BIT];
   wire [1:0] rstSel = timerCtrl_q[`RST_SEL_MSB:`RST_SEL_LSB];
   wire tickRun    = tickA && timerRun;
   wire resetOn0   = rstSel == RESET_ON_CH0;
   // the timer resets one count after the ch0 match, so the period is n+2
   wire [15:0] ch0Last = activeCmp[0] + `RESET_EXTRA_TICKS;
   wire ch0Hit     = resetOn0 && count_q == ch0Last;
   wire timerWrap  = tickRun && (ch0Hit || count_q == `TIMER_TOP);

   always_comb begin
      count_d = count_q;
      if (!timerRun) begin
         count_d = `TIMER_ZERO;
      end else if (timerWrap) begin
         count_d = `TIMER_ZERO;
      end else if (tickRun) begin
         count_d = count_q + 16'h0001;
      end
   end

   assign timerInfo = '{count: count_q, tick: tickRun, wrap: timerWrap};

   // ==========================================================
   // channels
   genvar j;
   generate
      for (j = 0; j < CHANNELS; j++) begin : g_chan
         wire chanSel   = doWrite && wrChanOk && wrIdx == j;
         wire ctrlWrite = chanSel && wrWaveBank;
         wire cmpWrite  = chanSel && wrCmpBank;
         wire [31:0] ctrlNew = mergeStrb({26'h0, waveCtrl_q[j]},
                                         wData_q, wStrb_q);
         wire [31:0] cmpNew  = mergeStrb({16'h0, activeCmp[j]},
                                         wData_q, wStrb_q);

         always_ff @(posedge clk) begin
            if (!rst_n) begin
               waveCtrl_q[j] <= chan_ctrl_s'(`RESET_WAVE_CTRL);
            end else if (ctrlWrite) begin
               waveCtrl_q[j] <= chan_ctrl_s'(ctrlNew[`WAVE_CTRL_MSB:0]);
            end
         end

         wave_channel u_chan (
            .clk        (clk),
            .rst_n      (rst_n),
            .timer      (timerInfo),
            .ctrl       (waveCtrl_q[j]),
            .chanEnable (chanEnable_q[j]),
            .funcSelect (funcSelect_q[j]),
            .cmpWrite   (cmpWrite),
            .cmpData    (cmpNew[15:0]),
            .activeCmp  (activeCmp[j]),
            .matchEvent (matchVec[j]),
            .pinLevel   (pinVec[j])
         );

         chk_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
            matchVec[j] |=> flags_q[j])
            else $error("match did not set the channel flag");

         chk_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
            flags_q[j] && !flagClear[j] |=> flags_q[j])
            else $error("channel flag dropped without a clear");

         chk_fixed_low: assert property (@(posedge clk) disable iff (!rst_n)
            resetOn0 && timerRun && count_q <= ch0Last && j != 0
            && {1'b0, activeCmp[j]} > {1'b0, ch0Last}
            |-> !matchVec[j])
            else $error("channel beyond ch0 period still matched");
      end
   endgenerate

   assign waveOutPin   = pinVec;
   assign matchIrqFlag = flags_q;

   // ==========================================================
   // registers
   // a match landing in the clear cycle survives: set wins over clear
   assign flags_d = (flags_q & ~flagClear) | matchVec;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         timerCtrl_q  <= `RESET_TIMER_CTRL;
         chanEnable_q <= `RESET_CHAN_BITS;
         funcSelect_q <= `RESET_CHAN_BITS;
         flags_q      <= `RESET_CHAN_BITS;
         count_q      <= `TIMER_ZERO;
      end else begin
         flags_q <= flags_d;
         count_q <= (doWrite && wrCount && timerRun)
                    ? countMerged[15:0] : count_d;
         if (doWrite && wrCtrl) begin
            timerCtrl_q <= ctrlMerged[4:0];
         end
         if (doWrite && wrEnable) begin
            chanEnable_q <= enMerged[7:0];
         end
         if (doWrite && wrFunc) begin
            funcSelect_q <= fsMerged[7:0];
         end
      end
   end

   // ==========================================================
   // write channel
   assign awready = !awHeld_q;
   assign wready  = !wHeld_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         awHeld_q <= 1'b0;
         wHeld_q  <= 1'b0;
         awAddr_q <= 12'h000;
         wData_q  <= 32'h0000_0000;
         wStrb_q  <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q  <= `RESP_OKAY;
      end else begin
         if (awvalid && !awHeld_q) begin
            awHeld_q <= 1'b1;
            awAddr_q <= awaddr;
         end
         if (wvalid && !wHeld_q) begin
            wHeld_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
         end
         if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // read channel
   wire rdWaveBank = (araddr & `OFF_BANK_MASK) == `OFF_WAVE_CTRL_BASE;
   wire rdCmpBank  = (araddr & `OFF_BANK_MASK) == `OFF_COMPARE_BASE;
   wire [2:0] rdIdx = araddr[4:2];
   wire rdAligned  = araddr[1:0] == 2'h0;

   always_comb begin
      readMux = 32'h0000_0000;
      readHit = rdAligned;
      if (araddr == `OFF_TIMER_CTRL) begin
         readMux = {27'h0, timerCtrl_q};
      end else if (araddr == `OFF_CHAN_ENABLE) begin
         readMux = {24'h0, chanEnable_q};
      end else if (araddr == `OFF_FUNC_SELECT) begin
         readMux = {24'h0, funcSelect_q};
      end else if (araddr == `OFF_MATCH_FLAGS) begin
         readMux = {24'h0, flags_q};
      end else if (araddr == `OFF_TIMER_COUNT) begin
         readMux = {16'h0, count_q};
      end else if (rdWaveBank && rdAligned) begin
         readMux = {26'h0, waveCtrl_q[rdIdx]};
      end else if (rdCmpBank && rdAligned) begin
         readMux = {16'h0, activeCmp[rdIdx]};
      end else begin
         readHit = 1'b0;
      end
   end

   assign arready = !rvalid_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= `RESP_OKAY;
      end else if (arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q  <= readMux;
         rresp_q  <= readHit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ==========================================================
   // checks
   chk_timer_stop: assert property (@(posedge clk) disable iff (!rst_n)
      !timerRun && !(doWrite && wrCtrl) |=> count_q == `TIMER_ZERO)
      else $error("stopped timer not held at zero");

   chk_timer_free: assert property (@(posedge clk) disable iff (!rst_n)
      tickRun && rstSel == RESET_FREE && count_q == `TIMER_TOP
      && !(doWrite && (wrCount || wrCtrl)) |=> count_q == `TIMER_ZERO)
      else $error("free timer did not wrap");

   chk_timer_ch0: assert property (@(posedge clk) disable iff (!rst_n)
      tickRun && ch0Hit && !(doWrite && (wrCount || wrCtrl))
      |=> count_q == `TIMER_ZERO)
      else $error("timer not reset after ch0 match");

   chk_write_resp: assert property (@(posedge clk) disable iff (!rst_n)
      doWrite |=> bvalid_q && !awHeld_q && !wHeld_q)
      else $error("write response missing");

   chk_read_resp: assert property (@(posedge clk) disable iff (!rst_n)
      arvalid && arready |=> rvalid_q ##0 rdata_q == $past(readMux))
      else $error("read data not returned");

   cov_ch0_reset: cover property (@(posedge clk) disable iff (!rst_n)
      tickRun && ch0Hit);
   cov_single_rise: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(pinVec[1]));
   cov_flag_race: cover property (@(posedge clk) disable iff (!rst_n)
      |(matchVec & flagClear));
   cov_free_wrap: cover property (@(posedge clk) disable iff (!rst_n)
      tickRun && count_q == `TIMER_TOP);

endmodule

// ---- tb/wave_load_model.sv ----
// far-side load model: measures high and low widths on every output pin
`timescale 1ns/1ps
module wave_load_model (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [7:0]       pin,
   output logic      [7:0][15:0] hiWidth,
   output logic      [7:0][15:0] loWidth
);
   logic [7:0][15:0] runLen;
   logic [7:0]       prevPin;

   // ==========================================================
   // width capture
   // widths are in clock cycles; a width only lands when the level
   // changes, so a pin that never leaves a level keeps that width 0
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hiWidth <= '0;
         loWidth <= '0;
         runLen  <= '0;
         prevPin <= 8'h00;
      end else begin
         for (int j = 0; j < 8; j++) begin
            if (pin[j] != prevPin[j]) begin
               if (prevPin[j]) begin
                  hiWidth[j] <= runLen[j];
               end else begin
                  loWidth[j] <= runLen[j];
               end
               runLen[j] <= 16'h0001;
            end else begin
               runLen[j] <= runLen[j] + 16'h0001;
            end
         end
         prevPin <= pin;
      end
   end
endmodule

// ---- tb/compare_waveform_channels_tb.sv ----
// self-checking bench for the eight waveform channels
`timescale 1ns/1ps
`include "compare_waveform_regs.svh"
module compare_waveform_channels_tb;
   import compare_waveform_pkg::*;
   logic              clk     = 1'b0;
   logic              rst_n   = 1'b0;
   logic              tickA   = 1'b0;
   logic [11:0]       awaddr  = 12'h000;
   logic              awvalid = 1'b0;
   logic [31:0]       wdata   = 32'h0;
   logic [3:0]        wstrb   = 4'h0;
   logic              wvalid  = 1'b0;
   logic              bready  = 1'b0;
   logic [11:0]       araddr  = 12'h000;
   logic              arvalid = 1'b0;
   logic              rready  = 1'b0;
   wire               awready, wready, bvalid, arready, rvalid;
   wire [1:0]         bresp, rresp;
   wire [31:0]        rdata;
   wire [7:0]         waveOutPin, matchIrqFlag;
   wire [7:0][15:0]   hiWidth, loWidth;
   int                failures  = 0;
   int                tests_run = 0;
   // ch0 sets n and the period is n+2 ticks; ticks come every second clock
   localparam int     TK = 2;
   localparam int     N  = 4;
   localparam logic [5:0]  CTRL_TAB [8] = '{6'h00, 6'h00, 6'h11, 6'h00,
                                            6'h09, 6'h20, 6'h28, 6'h08};
   localparam logic [15:0] CMP_TAB [8]  = '{16'h0004, 16'h0002, 16'h0001,
      16'h0006, 16'h0007, 16'h0002, 16'h0002, 16'h0002};

   always #2.5 clk = ~clk;
   always @(posedge clk) tickA <= ~tickA;

   compare_waveform_channels DUT (.clk(clk), .rst_n(rst_n), .tickA(tickA),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .waveOutPin(waveOutPin), .matchIrqFlag(matchIrqFlag));
   wave_load_model LOADS (.clk(clk), .rst_n(rst_n), .pin(waveOutPin),
      .hiWidth(hiWidth), .loWidth(loWidth));

   // ==========================================================
   // report
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      if (failures == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ==========================================================
   // bus master
   // ready and answers are looked at mid-cycle, where they are settled
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      logic awHit, wHit, done;
      @(posedge clk);
      awaddr <= a; wdata <= d; wstrb <= 4'hf;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      done = 1'b0;
      for (int n = 0; n < 100 && !done; n++) begin
         @(negedge clk);
         awHit = awvalid && awready;
         wHit = wvalid && wready;
         done = bvalid;
         if (done) check({30'h0, bresp}, {30'h0, er});
         @(posedge clk);
         if (awHit) awvalid <= 1'b0;
         if (wHit) wvalid <= 1'b0;
         if (done) bready <= 1'b0;
      end
      if (!done) begin failures++; test_done(); end
   endtask

   task automatic rdChk(input logic [11:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
      logic arHit, done;
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      done = 1'b0;
      for (int n = 0; n < 100 && !done; n++) begin
         @(negedge clk);
         arHit = arvalid && arready;
         done = rvalid;
         if (done) check(rdata, ed);
         if (done) check({30'h0, rresp}, {30'h0, er});
         @(posedge clk);
         if (arHit) arvalid <= 1'b0;
         if (done) rready <= 1'b0;
      end
      if (!done) begin failures++; test_done(); end
   endtask

   // ==========================================================
   // scenarios
   task automatic resetValues;
      @(negedge clk);
      check({24'h0, waveOutPin}, 32'h0);
      check({24'h0, matchIrqFlag}, 32'h0);
      rdChk(`OFF_TIMER_CTRL, 32'h0, `RESP_OKAY);
      rdChk(`OFF_WAVE_CTRL_BASE + 12'h01c, 32'h0, `RESP_OKAY);
      rdChk(`OFF_COMPARE_BASE + 12'h004, 32'h0, `RESP_OKAY);
      rdChk(12'h100, 32'h0, `RESP_SLVERR);
      wr(12'h100, 32'hffff, `RESP_SLVERR);
   endtask

   task automatic setupChannels;
      wr(`OFF_TIMER_CTRL, 32'h01, `RESP_OKAY);
      for (int j = 0; j < 8; j++) begin
         wr(`OFF_WAVE_CTRL_BASE + 12'(4 * j), {26'h0, CTRL_TAB[j]},
            `RESP_OKAY);
         wr(`OFF_COMPARE_BASE + 12'(4 * j), {16'h0, CMP_TAB[j]},
            `RESP_OKAY);
      end
      wr(`OFF_FUNC_SELECT, 32'h80, `RESP_OKAY);
      wr(`OFF_CHAN_ENABLE, 32'hbf, `RESP_OKAY);
      wr(`OFF_TIMER_CTRL, 32'h11, `RESP_OKAY);
      repeat (400) @(posedge clk);
   endtask

   task automatic checkWaves;
      @(negedge clk);
      check({16'h0, loWidth[0]}, 32'(TK * 4));
      check({16'h0, hiWidth[0]}, 32'(TK * (N + 2 - 4)));
      check({16'h0, loWidth[1]}, 32'(TK * 2));
      check({16'h0, hiWidth[1]}, 32'(TK * (N + 2 - 2)));
      check({16'h0, loWidth[2]}, 32'(TK * (N + 2)));
      check({16'h0, hiWidth[2]}, 32'(TK * (N + 2)));
      check({16'h0, hiWidth[5]}, 32'(TK * 2));
      check({16'h0, loWidth[5]}, 32'(TK * (N + 2 - 2)));
      check({16'h0, hiWidth[3]}, 32'h0);
      check({16'h0, hiWidth[4]}, 32'h0);
      check({24'h0, waveOutPin & 8'hd8}, 32'h90);
      rdChk(`OFF_MATCH_FLAGS, 32'h27, `RESP_OKAY);
      check({24'h0, matchIrqFlag}, 32'h27);
   endtask

   task automatic clearAndReload;
      wr(`OFF_TIMER_CTRL, 32'h01, `RESP_OKAY);
      wr(`OFF_MATCH_FLAGS, 32'hff, `RESP_OKAY);
      rdChk(`OFF_MATCH_FLAGS, 32'h0, `RESP_OKAY);
      wr(`OFF_COMPARE_BASE + 12'h004, 32'h3, `RESP_OKAY);
      rdChk(`OFF_COMPARE_BASE + 12'h004, 32'h3, `RESP_OKAY);
      wr(`OFF_COMPARE_BASE + 12'h008, 32'h5, `RESP_OKAY);
      rdChk(`OFF_COMPARE_BASE + 12'h008, 32'h1, `RESP_OKAY);
   endtask

   task automatic disableChannel;
      wr(`OFF_WAVE_CTRL_BASE + 12'h004, 32'h08, `RESP_OKAY);
      wr(`OFF_CHAN_ENABLE, 32'hbd, `RESP_OKAY);
      repeat (4) @(posedge clk);
      @(negedge clk);
      check({24'h0, waveOutPin & 8'hd2}, 32'h92);
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      resetValues();
      setupChannels();
      checkWaves();
      clearAndReload();
      disableChannel();
      test_done();
   end
endmodule
